// >>> hw/emd_regs.svh
// constants of the extended memory operation datapath
`ifndef EMD_REGS_SVH
`define EMD_REGS_SVH
`define EMD_DATA_W 8
`define EMD_ADDR_W 12
`define EMD_BIT_W 3
`define EMD_REG_ADDR_W 2
`define EMD_REG_ACCUM 2'h0
`define EMD_REG_STATUS 2'h1
`define EMD_STATUS_W 6
`define EMD_ACCUM_RESET 8'h00
`define EMD_STATUS_RESET 6'h00
`define EMD_BYTE_ZERO 8'h00
`define EMD_BYTE_ONE 8'h01
`define EMD_BYTE_ONES 8'hff
`define EMD_MSB 7
`define EMD_LSB 0
`define EMD_NIB_HI_TOP 7
`define EMD_NIB_HI_BOT 4
`define EMD_NIB_LO_TOP 3
`define EMD_NIB_LO_BOT 0
`endif

// >>> hw/emd_pkg.sv
// types shared by the extended memory operation datapath
`include "emd_regs.svh"
package emd_pkg;
    typedef enum logic [4:0] {
        EMD_NO_OP = 5'h00,
        EMD_OR_TO_MEMORY_OP = 5'h01,
        EMD_ROTATE_LEFT_MEM_OP = 5'h02,
        EMD_ROTATE_LEFT_TO_ACCUM_OP = 5'h03,
        EMD_ROTATE_LEFT_CARRY_MEM_OP = 5'h04,
        EMD_ROTATE_LEFT_CARRY_ACCUM_OP = 5'h05,
        EMD_ROTATE_RIGHT_MEM_OP = 5'h06,
        EMD_ROTATE_RIGHT_TO_ACCUM_OP = 5'h07,
        EMD_ROTATE_RIGHT_CARRY_MEM_OP = 5'h08,
        EMD_ROTATE_RIGHT_CARRY_ACCUM_OP = 5'h09,
        EMD_SUBTRACT_BORROW_OP = 5'h0a,
        EMD_SUBTRACT_BORROW_TO_MEM_OP = 5'h0b,
        EMD_SUBTRACT_OP = 5'h0c,
        EMD_SUBTRACT_TO_MEM_OP = 5'h0d,
        EMD_DECREMENT_SKIP_ZERO_OP = 5'h0e,
        EMD_DECREMENT_SKIP_ZERO_ACCUM_OP = 5'h0f,
        EMD_INCREMENT_SKIP_ZERO_OP = 5'h10,
        EMD_INCREMENT_SKIP_ZERO_ACCUM_OP = 5'h11,
        EMD_SET_ALL_ONES_OP = 5'h12,
        EMD_SET_BIT_OP = 5'h13,
        EMD_SKIP_NONZERO_OP = 5'h14,
        EMD_SKIP_NONZERO_BIT_OP = 5'h15,
        EMD_NIBBLE_EXCHANGE_OP = 5'h16,
        EMD_NIBBLE_EXCHANGE_ACCUM_OP = 5'h17
    } emd_op_t;

    typedef enum logic [1:0] {
        EMD_ST_IDLE = 2'b00,
        EMD_ST_FETCH = 2'b01,
        EMD_ST_EXEC = 2'b10,
        EMD_ST_DUMMY = 2'b11
    } emd_state_t;

    typedef struct packed {
        logic chainedZero;
        logic specialZero;
        logic overflow;
        logic zero;
        logic auxCarry;
        logic carry;
    } emd_flags_t;

    typedef struct packed {
        emd_op_t op;
        logic [`EMD_ADDR_W-1:0] addr;
        logic [`EMD_BIT_W-1:0] bitSel;
    } emd_req_t;
endpackage

// >>> hw/emd_subtractor.sv
// eight bit subtractor with borrow, carry, nibble carry and overflow
`timescale 1ns/100ps
`include "emd_regs.svh"
module emd_subtractor import emd_pkg::*; (
    input wire logic [`EMD_DATA_W-1:0] minuend,
    input wire logic [`EMD_DATA_W-1:0] subtrahend,
    input wire logic borrowIn,
    output logic [`EMD_DATA_W-1:0] difference,
    output logic carryOut,
    output logic auxCarryOut,
    output logic overflowOut
);
    logic [`EMD_DATA_W:0] wide;
    logic [`EMD_NIB_HI_BOT:0] low;

    always_comb begin
        wide = {1'b0, minuend} - {1'b0, subtrahend} - {{`EMD_DATA_W{1'b0}}, borrowIn};
        low = {1'b0, minuend[`EMD_NIB_LO_TOP:`EMD_NIB_LO_BOT]}
            - {1'b0, subtrahend[`EMD_NIB_LO_TOP:`EMD_NIB_LO_BOT]}
            - {{`EMD_NIB_HI_BOT{1'b0}}, borrowIn};
        difference = wide[`EMD_DATA_W-1:0];
        // carry set when no borrow, cleared on negative result
        carryOut = ~wide[`EMD_DATA_W];
        auxCarryOut = ~low[`EMD_NIB_HI_BOT];
        overflowOut = (minuend[`EMD_MSB] ^ subtrahend[`EMD_MSB]) & (minuend[`EMD_MSB] ^ wide[`EMD_MSB]);
    end
endmodule // emd_subtractor

// >>> hw/emd_datapath.sv
// execution datapath of the extended data memory instructions
//
// Behaviour
// - full memory address, no bank selection
// - or to memory, zero flag only
// - rotate left memory, bit 7 to 0
// - rotate left to accumulator, memory kept
// - rotate left through carry, carry only
// - rotate right, bit 0 to 7
// - rotate right through carry, carry only
// - subtract with borrow into accumulator, six flags
// - subtract with borrow into memory byte
// - carry clear on negative difference
// - plain subtract, accumulator or memory, six flags
// - decrement memory, skip on zero
// - decrement into accumulator, skip on zero
// - increment memory, skip on zero
// - increment into accumulator, skip on zero
// - skip instructions take an extra cycle
// - set byte to ones or one bit
// - skip when byte nonzero
// - skip when selected bit nonzero
// - swap nibbles of memory byte
// - swap nibbles into accumulator
`timescale 1ns/100ps
`include "emd_regs.svh"
module emd_datapath import emd_pkg::*; (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic opStart,
    input wire emd_req_t opReq,
    output logic opBusy,
    output logic opDone,
    output logic skipNext,
    output logic [`EMD_ADDR_W-1:0] memAddr,
    output logic memRd,
    input wire logic [`EMD_DATA_W-1:0] memRdData,
    output logic memWr,
    output logic [`EMD_DATA_W-1:0] memWrData,
    input wire logic [`EMD_REG_ADDR_W-1:0] regAddr,
    input wire logic [`EMD_DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [`EMD_DATA_W-1:0] regRdData,
    output logic [`EMD_DATA_W-1:0] accumulator,
    output emd_flags_t flags
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic isSkipOp(input emd_op_t op);
        unique case (op)
            EMD_DECREMENT_SKIP_ZERO_OP, EMD_DECREMENT_SKIP_ZERO_ACCUM_OP,
            EMD_INCREMENT_SKIP_ZERO_OP, EMD_INCREMENT_SKIP_ZERO_ACCUM_OP,
            EMD_SKIP_NONZERO_OP, EMD_SKIP_NONZERO_BIT_OP: isSkipOp = 1'b1;
            default: isSkipOp = 1'b0;
        endcase
    endfunction

    function automatic logic [`EMD_DATA_W-1:0] bitMask(input logic [`EMD_BIT_W-1:0] sel);
        bitMask = `EMD_BYTE_ONE << sel;
    endfunction

    function automatic logic isSubOp(input emd_op_t op);
        isSubOp = (op == EMD_SUBTRACT_BORROW_OP) || (op == EMD_SUBTRACT_BORROW_TO_MEM_OP)
            || (op == EMD_SUBTRACT_OP) || (op == EMD_SUBTRACT_TO_MEM_OP);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    emd_state_t state;
    emd_state_t next_state;
    emd_req_t cur;
    logic skipPending;
    logic [`EMD_DATA_W-1:0] subDiff;
    logic subCarry;
    logic subAux;
    logic subOverflow;
    logic subBorrow;
    logic [`EMD_DATA_W-1:0] next_result;
    logic next_toMem;
    logic next_toAccum;
    logic next_skip;
    emd_flags_t next_flags;
    logic opTaken;
    logic memWrGo;
    logic accumRegWr;
    logic statusRegWr;

    ////////////////////////////////////////////////////////////////////////////////
    // strobes decoded once

    assign opTaken = (state == EMD_ST_IDLE) && opStart;
    assign memWrGo = (state == EMD_ST_EXEC) && next_toMem;
    assign accumRegWr = regWr && (regAddr == `EMD_REG_ACCUM);
    assign statusRegWr = regWr && (regAddr == `EMD_REG_STATUS);

    ////////////////////////////////////////////////////////////////////////////////
    // subtractor

    // borrow is the inverted carry only for the borrow forms
    assign subBorrow = ((cur.op == EMD_SUBTRACT_BORROW_OP) || (cur.op == EMD_SUBTRACT_BORROW_TO_MEM_OP))
        & ~flags.carry;

    emd_subtractor subUnit (
        .minuend(accumulator),
        .subtrahend(memRdData),
        .borrowIn(subBorrow),
        .difference(subDiff),
        .carryOut(subCarry),
        .auxCarryOut(subAux),
        .overflowOut(subOverflow)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // operation decode, valid while the byte is on memRdData

    always_comb begin
        next_result = memRdData;
        next_toMem = 1'b0;
        next_toAccum = 1'b0;
        next_skip = 1'b0;
        next_flags = flags;
        unique case (cur.op)
            EMD_OR_TO_MEMORY_OP: begin
                next_result = accumulator | memRdData;
                next_toMem = 1'b1;
                next_flags.zero = (next_result == `EMD_BYTE_ZERO);
            end
            EMD_ROTATE_LEFT_MEM_OP, EMD_ROTATE_LEFT_TO_ACCUM_OP: begin
                next_result = {memRdData[`EMD_MSB-1:`EMD_LSB], memRdData[`EMD_MSB]};
                next_toMem = (cur.op == EMD_ROTATE_LEFT_MEM_OP);
                next_toAccum = (cur.op == EMD_ROTATE_LEFT_TO_ACCUM_OP);
            end
            EMD_ROTATE_LEFT_CARRY_MEM_OP, EMD_ROTATE_LEFT_CARRY_ACCUM_OP: begin
                next_result = {memRdData[`EMD_MSB-1:`EMD_LSB], flags.carry};
                next_flags.carry = memRdData[`EMD_MSB];
                next_toMem = (cur.op == EMD_ROTATE_LEFT_CARRY_MEM_OP);
                next_toAccum = (cur.op == EMD_ROTATE_LEFT_CARRY_ACCUM_OP);
            end
            EMD_ROTATE_RIGHT_MEM_OP, EMD_ROTATE_RIGHT_TO_ACCUM_OP: begin
                next_result = {memRdData[`EMD_LSB], memRdData[`EMD_MSB:`EMD_LSB+1]};
                next_toMem = (cur.op == EMD_ROTATE_RIGHT_MEM_OP);
                next_toAccum = (cur.op == EMD_ROTATE_RIGHT_TO_ACCUM_OP);
            end
            EMD_ROTATE_RIGHT_CARRY_MEM_OP, EMD_ROTATE_RIGHT_CARRY_ACCUM_OP: begin
                next_result = {flags.carry, memRdData[`EMD_MSB:`EMD_LSB+1]};
                next_flags.carry = memRdData[`EMD_LSB];
                next_toMem = (cur.op == EMD_ROTATE_RIGHT_CARRY_MEM_OP);
                next_toAccum = (cur.op == EMD_ROTATE_RIGHT_CARRY_ACCUM_OP);
            end
            EMD_SUBTRACT_BORROW_OP, EMD_SUBTRACT_BORROW_TO_MEM_OP,
            EMD_SUBTRACT_OP, EMD_SUBTRACT_TO_MEM_OP: begin
                next_result = subDiff;
                next_toMem = (cur.op == EMD_SUBTRACT_BORROW_TO_MEM_OP) || (cur.op == EMD_SUBTRACT_TO_MEM_OP);
                next_toAccum = ~next_toMem;
                next_flags.carry = subCarry;
                next_flags.auxCarry = subAux;
                next_flags.overflow = subOverflow;
                next_flags.zero = (subDiff == `EMD_BYTE_ZERO);
                next_flags.specialZero = subOverflow ^ subDiff[`EMD_MSB];
                // chained zero keeps the previous zero history only for the borrow forms
                next_flags.chainedZero = (subDiff == `EMD_BYTE_ZERO)
                    & (((cur.op == EMD_SUBTRACT_OP) || (cur.op == EMD_SUBTRACT_TO_MEM_OP)) | flags.chainedZero);
            end
            EMD_DECREMENT_SKIP_ZERO_OP, EMD_DECREMENT_SKIP_ZERO_ACCUM_OP: begin
                next_result = memRdData - `EMD_BYTE_ONE;
                next_toMem = (cur.op == EMD_DECREMENT_SKIP_ZERO_OP);
                next_toAccum = (cur.op == EMD_DECREMENT_SKIP_ZERO_ACCUM_OP);
                next_skip = (next_result == `EMD_BYTE_ZERO);
            end
            EMD_INCREMENT_SKIP_ZERO_OP, EMD_INCREMENT_SKIP_ZERO_ACCUM_OP: begin
                next_result = memRdData + `EMD_BYTE_ONE;
                next_toMem = (cur.op == EMD_INCREMENT_SKIP_ZERO_OP);
                next_toAccum = (cur.op == EMD_INCREMENT_SKIP_ZERO_ACCUM_OP);
                next_skip = (next_result == `EMD_BYTE_ZERO);
            end
            EMD_SET_ALL_ONES_OP: begin
                next_result = `EMD_BYTE_ONES;
                next_toMem = 1'b1;
            end
            EMD_SET_BIT_OP: begin
                next_result = memRdData | bitMask(cur.bitSel);
                next_toMem = 1'b1;
            end
            EMD_SKIP_NONZERO_OP: begin
                next_skip = (memRdData != `EMD_BYTE_ZERO);
            end
            EMD_SKIP_NONZERO_BIT_OP: begin
                next_skip = ((memRdData & bitMask(cur.bitSel)) != `EMD_BYTE_ZERO);
            end
            EMD_NIBBLE_EXCHANGE_OP, EMD_NIBBLE_EXCHANGE_ACCUM_OP: begin
                next_result = {memRdData[`EMD_NIB_LO_TOP:`EMD_NIB_LO_BOT],
                    memRdData[`EMD_NIB_HI_TOP:`EMD_NIB_HI_BOT]};
                next_toMem = (cur.op == EMD_NIBBLE_EXCHANGE_OP);
                next_toAccum = (cur.op == EMD_NIBBLE_EXCHANGE_ACCUM_OP);
            end
            default: begin
                next_result = memRdData;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencing

    always_comb begin
        next_state = state;
        unique case (state)
            EMD_ST_IDLE: begin
                if (opStart) begin
                    next_state = EMD_ST_FETCH;
                end
            end
            EMD_ST_FETCH: next_state = EMD_ST_EXEC;
            EMD_ST_EXEC: next_state = isSkipOp(cur.op) ? EMD_ST_DUMMY : EMD_ST_IDLE;
            EMD_ST_DUMMY: next_state = EMD_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= EMD_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // request held for the whole op
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
        end else if (opTaken) begin
            cur <= opReq;
        end
    end

    // busy from the accepting edge to the last edge of the op
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            opBusy <= 1'b0;
        end else begin
            opBusy <= (next_state != EMD_ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // memory port

    // read side: full address straight from the request, no bank
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            memAddr <= '0;
            memRd <= 1'b0;
        end else begin
            memRd <= opTaken;
            if (opTaken) begin
                memAddr <= opReq.addr;
            end
        end
    end

    // write side: one strobe after the execute cycle of a memory destination op
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            memWr <= 1'b0;
            memWrData <= `EMD_BYTE_ZERO;
        end else begin
            memWr <= memWrGo;
            if (memWrGo) begin
                memWrData <= next_result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // completion and skip

    // skip condition held over the dummy cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            skipPending <= 1'b0;
        end else if (state == EMD_ST_EXEC) begin
            skipPending <= next_skip;
        end
    end

    // skip ops end after the dummy cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            opDone <= 1'b0;
        end else begin
            opDone <= (state == EMD_ST_EXEC && !isSkipOp(cur.op)) || (state == EMD_ST_DUMMY);
        end
    end

    // skip request rides on the done pulse of a skip op
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            skipNext <= 1'b0;
        end else begin
            skipNext <= (state == EMD_ST_DUMMY) && skipPending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // accumulator and flags, datapath wins over a register write

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            accumulator <= `EMD_ACCUM_RESET;
        end else if (state == EMD_ST_EXEC && next_toAccum) begin
            accumulator <= next_result;
        end else if (accumRegWr) begin
            accumulator <= regWrData;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flags <= `EMD_STATUS_RESET;
        end else if (state == EMD_ST_EXEC) begin
            flags <= next_flags;
        end else if (statusRegWr) begin
            flags <= regWrData[`EMD_STATUS_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register read port

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= `EMD_BYTE_ZERO;
        end else if (regRd) begin
            unique case (regAddr)
                `EMD_REG_ACCUM: regRdData <= accumulator;
                `EMD_REG_STATUS: regRdData <= {{(`EMD_DATA_W-`EMD_STATUS_W){1'b0}}, flags};
                default: regRdData <= `EMD_BYTE_ZERO;
            endcase
        end else begin
            regRdData <= `EMD_BYTE_ZERO;
        end
    end
endmodule // emd_datapath

// >>> tb/emd_datapath_chk.sv
// concurrent checks on the extended memory operation datapath ports
`timescale 1ns/100ps
`include "emd_regs.svh"
module emd_datapath_chk import emd_pkg::*; (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic opStart,
    input wire emd_req_t opReq,
    input wire logic opBusy,
    input wire logic opDone,
    input wire logic skipNext,
    input wire logic [`EMD_ADDR_W-1:0] memAddr,
    input wire logic memRd,
    input wire logic [`EMD_DATA_W-1:0] memRdData,
    input wire logic memWr,
    input wire logic [`EMD_DATA_W-1:0] memWrData,
    input wire logic [`EMD_DATA_W-1:0] accumulator,
    input wire emd_flags_t flags
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    emd_op_t curOp;
    logic rdPend;
    logic [`EMD_DATA_W-1:0] rdByte;
    logic isSkip;
    ////////////////////////////////////////
    // op of the running request and the byte it fetched
    assign isSkip = opReq.op inside {[5'h0e:5'h11], 5'h14, 5'h15};
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            curOp <= EMD_NO_OP;
        end else if (opStart && !opBusy) begin
            curOp <= opReq.op;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdPend <= 1'b0;
            rdByte <= 8'h00;
        end else begin
            rdPend <= memRd;
            if (rdPend) begin
                rdByte <= memRdData;
            end
        end
    end
    ////////////////////////////////////////
    chk_full_addr: assert property (opStart && !opBusy |=> memRd && memAddr == $past(opReq.addr))
        else $error("memory address not taken whole");
    chk_plain_len: assert property (opStart && !opBusy && !isSkip |=> !opDone [*2] ##1 opDone)
        else $error("plain op length wrong");
    chk_skip_len: assert property (opStart && !opBusy && isSkip |=> !opDone [*3] ##1 opDone)
        else $error("skip op length wrong");
    chk_or_zero: assert property (opDone && curOp == EMD_OR_TO_MEMORY_OP |-> memWr
        && memWrData == (accumulator | rdByte) && flags.zero == (memWrData == 8'h00)
        && (flags & 6'h3b) == ($past(flags) & 6'h3b)) else $error("or to memory wrong");
    chk_rotl_mem: assert property (opDone && curOp == EMD_ROTATE_LEFT_MEM_OP |-> memWr
        && memWrData == {rdByte[6:0], rdByte[7]} && $stable(flags)) else $error("rotate left wrong");
    chk_sub_mem: assert property (opDone && curOp == EMD_SUBTRACT_TO_MEM_OP |-> memWr && $stable(accumulator)
        && flags.carry == (accumulator >= rdByte) && memWrData == accumulator - rdByte)
        else $error("subtract to memory wrong");
    chk_dec_skip: assert property (opDone && curOp == EMD_DECREMENT_SKIP_ZERO_OP
        |-> skipNext == (rdByte == 8'h01)) else $error("decrement skip wrong");
    chk_nz_skip: assert property (opDone && curOp == EMD_SKIP_NONZERO_OP
        |-> skipNext == (rdByte != 8'h00)) else $error("nonzero skip wrong");
    chk_swap_acc: assert property (opDone && curOp == EMD_NIBBLE_EXCHANGE_ACCUM_OP |-> !memWr
        && accumulator == {rdByte[3:0], rdByte[7:4]}) else $error("nibble swap to accumulator wrong");
endmodule // emd_datapath_chk

bind emd_datapath emd_datapath_chk i_chk (.sys_clk, .nrst, .opStart, .opReq, .opBusy, .opDone, .skipNext,
    .memAddr, .memRd, .memRdData, .memWr, .memWrData, .accumulator, .flags);

// >>> tb/emd_mem_model.sv
// data memory model on the far side of the datapath
`timescale 1ns/100ps
`include "emd_regs.svh"
module emd_mem_model import emd_pkg::*; (
    input wire logic sys_clk,
    input wire logic [`EMD_ADDR_W-1:0] memAddr,
    input wire logic memRd,
    input wire logic memWr,
    input wire logic [`EMD_DATA_W-1:0] memWrData,
    output logic [`EMD_DATA_W-1:0] memRdData
);
    logic [`EMD_DATA_W-1:0] mem [0:4095];
    initial memRdData = 8'h00;
    // whole address space, no bank; read data only the cycle after the strobe
    always @(posedge sys_clk) begin
        if (memWr) begin
            mem[memAddr] <= memWrData;
        end
        if (memRd) begin
            memRdData <= mem[memAddr];
        end else begin
            memRdData <= ~memRdData;
        end
    end
endmodule // emd_mem_model

// >>> tb/tb_emd_datapath.sv
// self-checking testbench of the extended memory operation datapath
`timescale 1ns/100ps
`include "emd_regs.svh"
module tb_emd_datapath import emd_pkg::*;;
    logic sys_clk, nrst, opStart, opBusy, opDone, skipNext, memRd, memWr, regWr, regRd;
    emd_req_t opReq;
    logic [`EMD_ADDR_W-1:0] memAddr;
    logic [`EMD_DATA_W-1:0] memRdData, memWrData, regWrData, regRdData, accumulator, acc0;
    logic [`EMD_REG_ADDR_W-1:0] regAddr;
    emd_flags_t flags;
    logic [5:0] st0;
    logic [7:0] rdv;
    int failCount = 0;
    int nTests = 0;
    int cyc = 0;
    emd_datapath i_dut (.sys_clk, .nrst, .opStart, .opReq, .opBusy, .opDone, .skipNext, .memAddr, .memRd,
        .memRdData, .memWr, .memWrData, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .accumulator, .flags);
    emd_mem_model i_mem (.sys_clk, .memAddr, .memRd, .memWr, .memWrData, .memRdData);
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failCount++;
            finalReport();
        end
    end
    ////////////////////////////////////////
    task finalReport;
        if (failCount == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        d = regRdData;
    endtask
    // one op on byte m at an address made from the op code
    task automatic op_case(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] m, input logic [7:0] em,
            input logic [7:0] ea, input logic [5:0] es, input logic sk);
        int n;
        logic [7:0] rd;
        i_mem.mem[{op, 7'h35}] = m;
        reg_wr(2'h0, acc0);
        reg_wr(2'h1, {2'b00, st0});
        @(posedge sys_clk);
        opStart <= 1'b1;
        opReq <= '{emd_op_t'(op), {op, 7'h35}, bs};
        @(posedge sys_clk);
        opStart <= 1'b0;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
            if (n == 1) check("busy", {7'h00, opBusy}, 8'h01);
        end while (opDone !== 1'b1 && n < 8);
        check("idle", {7'h00, opBusy}, 8'h00);
        check("cycles", 8'(n), (op inside {[5'h0e:5'h11], 5'h14, 5'h15}) ? 8'h04 : 8'h03);
        check("skip", {7'h00, skipNext}, {7'h00, sk});
        @(negedge sys_clk);
        check("memory", i_mem.mem[{op, 7'h35}], em);
        check("accumulator", accumulator, ea);
        reg_rd(2'h1, rd);
        check("status", rd, {2'b00, es});
    endtask
    ////////////////////////////////////////
    task t_rotate;
        acc0 = 8'h00;
        st0 = 6'h3f;
        op_case(5'h02, 3'h0, 8'h40, 8'h80, 8'h00, 6'h3f, 1'b0);
        op_case(5'h03, 3'h0, 8'h40, 8'h40, 8'h80, 6'h3f, 1'b0);
        op_case(5'h04, 3'h0, 8'h40, 8'h81, 8'h00, 6'h3e, 1'b0);
        op_case(5'h05, 3'h0, 8'h40, 8'h40, 8'h81, 6'h3e, 1'b0);
        op_case(5'h06, 3'h0, 8'h40, 8'h20, 8'h00, 6'h3f, 1'b0);
        op_case(5'h07, 3'h0, 8'h40, 8'h40, 8'h20, 6'h3f, 1'b0);
        op_case(5'h08, 3'h0, 8'h40, 8'ha0, 8'h00, 6'h3e, 1'b0);
        op_case(5'h09, 3'h0, 8'h40, 8'h40, 8'ha0, 6'h3e, 1'b0);
    endtask
    task t_subtract;
        acc0 = 8'h10;
        st0 = 6'h00;
        op_case(5'h0a, 3'h0, 8'h20, 8'h20, 8'hef, 6'h10, 1'b0);
        op_case(5'h0b, 3'h0, 8'h20, 8'hef, 8'h10, 6'h10, 1'b0);
        op_case(5'h0c, 3'h0, 8'h20, 8'h20, 8'hf0, 6'h12, 1'b0);
        op_case(5'h0d, 3'h0, 8'h20, 8'hf0, 8'h10, 6'h12, 1'b0);
        acc0 = 8'h20;
        st0 = 6'h01;
        op_case(5'h0a, 3'h0, 8'h20, 8'h20, 8'h00, 6'h07, 1'b0);
        op_case(5'h0c, 3'h0, 8'h20, 8'h20, 8'h00, 6'h27, 1'b0);
        acc0 = 8'h80;
        op_case(5'h0d, 3'h0, 8'h01, 8'h7f, 8'h80, 6'h19, 1'b0);
    endtask
    task t_skip;
        acc0 = 8'h55;
        st0 = 6'h2a;
        op_case(5'h0e, 3'h0, 8'h01, 8'h00, 8'h55, 6'h2a, 1'b1);
        op_case(5'h0e, 3'h0, 8'h00, 8'hff, 8'h55, 6'h2a, 1'b0);
        op_case(5'h0f, 3'h0, 8'h01, 8'h01, 8'h00, 6'h2a, 1'b1);
        op_case(5'h10, 3'h0, 8'hff, 8'h00, 8'h55, 6'h2a, 1'b1);
        op_case(5'h11, 3'h0, 8'hfe, 8'hfe, 8'hff, 6'h2a, 1'b0);
        op_case(5'h14, 3'h0, 8'h00, 8'h00, 8'h55, 6'h2a, 1'b0);
        op_case(5'h14, 3'h0, 8'h10, 8'h10, 8'h55, 6'h2a, 1'b1);
        op_case(5'h15, 3'h4, 8'h10, 8'h10, 8'h55, 6'h2a, 1'b1);
        op_case(5'h15, 3'h3, 8'h10, 8'h10, 8'h55, 6'h2a, 1'b0);
    endtask
    task t_misc;
        acc0 = 8'h0f;
        st0 = 6'h3f;
        op_case(5'h12, 3'h0, 8'h12, 8'hff, 8'h0f, 6'h3f, 1'b0);
        op_case(5'h13, 3'h5, 8'h01, 8'h21, 8'h0f, 6'h3f, 1'b0);
        op_case(5'h16, 3'h0, 8'ha5, 8'h5a, 8'h0f, 6'h3f, 1'b0);
        op_case(5'h17, 3'h0, 8'ha5, 8'ha5, 8'h5a, 6'h3f, 1'b0);
        op_case(5'h01, 3'h0, 8'h30, 8'h3f, 8'h0f, 6'h3b, 1'b0);
        acc0 = 8'h00;
        st0 = 6'h3b;
        op_case(5'h01, 3'h0, 8'h00, 8'h00, 8'h00, 6'h3f, 1'b0);
        op_case(5'h00, 3'h0, 8'h5a, 8'h5a, 8'h00, 6'h3b, 1'b0);
        op_case(5'h1f, 3'h0, 8'ha5, 8'ha5, 8'h00, 6'h3b, 1'b0);
        reg_wr(2'h1, 8'hff);
        reg_rd(2'h1, rdv);
        check("status top bits", rdv, 8'h3f);
        reg_rd(2'h3, rdv);
        check("unmapped read", rdv, 8'h00);
    endtask
    initial begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        opStart = 1'b0;
        opReq = '0;
        regAddr = 2'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        t_rotate();
        t_subtract();
        t_skip();
        t_misc();
        finalReport();
    end
endmodule // tb_emd_datapath
